// ===== ffp_filter_port.sv
// filter core port logic: stream handshake, coefficient reload, ratio strobe
// ---------------------------------------------------------------
// Function
// - everything but the low reset synchronous to one system clock
// - low reset clears core asynchronously
// - single-channel fast: even inphase, odd quadrature
// - multi-channel fast: ports carry different channels
// - single-channel fast: even/odd results paired
// - multi-channel fast: output ports different channels
// - low speed uses sample_in and sample_out
// - capture input only when valid high
// - qualifier high exactly when output valid
// - ready high when next sample acceptable
// - write strobe stores tap weight word
// - commit switches to newly loaded weights
// - weight port widened for symmetric interpolation
// - channel zero result carries output mark
// - ratio latch makes factor active
// - gate low freezes everything
// - sync clear returns registers to reset
// - ratio change drops ready several cycles
// - reload mode: not ready until commit
// ---------------------------------------------------------------
//
// Implementation choices: the auto-incrementing tap index and the write-and-commit strobe port.
`timescale 1ns/1ps
`default_nettype none

module ffp_filter_port (
	// clock and reset
	input  wire logic                           sys_clk_in,
	input  wire logic                           resetn_in,
	input  wire logic                           sync_clear_in,
	input  wire logic                           clock_gate_enable_in,
	// mode select
	input  wire ffp_pkg::ffp_mode_t             mode_in,
	// sample input
	input  wire logic [ffp_pkg::DATA_W-1:0]     sample_in,
	input  wire ffp_pkg::ffp_pair_in_t          pair_in,
	input  wire logic                           sample_in_valid_in,
	input  wire logic                           first_channel_in_mark_in,
	output logic                                accept_ready_out,
	// result output
	output logic [ffp_pkg::OUT_W-1:0]           sample_out,
	output ffp_pkg::ffp_pair_out_t              pair_out,
	output logic                                result_qualifier_out,
	output logic                                first_channel_out_mark_out,
	// coefficient reload
	// widened weight port
	input  wire logic [ffp_pkg::COEF_IN_W-1:0]  tap_weight_in,
	input  wire logic                           tap_weight_write_in,
	input  wire logic                           tap_weight_commit_in,
	// variable ratio
	input  wire logic [ffp_pkg::FACTOR_W-1:0]   upsample_ratio_in,
	input  wire logic                           ratio_latch_in,
	output logic [ffp_pkg::FACTOR_W-1:0]        active_ratio_out
);
	import ffp_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic signed [COEF_IN_W-1:0] load_reg [TAPS];
	logic signed [COEF_IN_W-1:0] live_reg [TAPS];
	logic signed [DATA_W-1:0]    tap_a_reg [TAPS];
	logic signed [DATA_W-1:0]    tap_b_reg [TAPS];
	logic [TAP_IDX_W-1:0]        load_idx_reg;
	ffp_state_t                  state_reg;
	logic [SETTLE_W-1:0]         settle_reg;
	logic [FACTOR_W-1:0]         ratio_reg;
	logic                        mark_d_reg;
	logic                        take;
	logic                        run;

	// gate low freezes all state; clear forces reset values
	// gate freezes state
	assign run  = clock_gate_enable_in;
	assign take = run && sample_in_valid_in && accept_ready_out;

	// dot product of one tap line against the live weights
	function automatic logic signed [ACC_W-1:0] dot(
		input logic signed [DATA_W-1:0]    t [TAPS],
		input logic signed [COEF_IN_W-1:0] c [TAPS]
	);
		logic signed [ACC_W-1:0] acc;
		acc = '0;
		for (int i = 0; i < TAPS; i++) begin
			acc = acc + ACC_W'(t[i]) * ACC_W'(c[i]);
		end
		return acc;
	endfunction

	// trim accumulator to output width, plain truncation of low bits
	function automatic logic [OUT_W-1:0] trim(input logic signed [ACC_W-1:0] a);
		return a[COEF_W +: OUT_W];
	endfunction

	// ---------------------------------------------------------------
	// coefficient load and commit
	// ---------------------------------------------------------------
	// store written weight
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			load_idx_reg <= '0;
			for (int i = 0; i < TAPS; i++) begin
				load_reg[i] <= '0;
			end
		end else if (run && sync_clear_in) begin
			load_idx_reg <= '0;
			for (int i = 0; i < TAPS; i++) begin
				load_reg[i] <= '0;
			end
		end else if (run) begin
			if (tap_weight_write_in) begin
				load_reg[load_idx_reg] <= tap_weight_in;
				load_idx_reg <= load_idx_reg + 1'b1;
			end else if (tap_weight_commit_in) begin
				load_idx_reg <= '0; // next batch starts from the first tap
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < TAPS; i++) begin
				live_reg[i] <= '0;
			end
		end else if (run && sync_clear_in) begin
			for (int i = 0; i < TAPS; i++) begin
				live_reg[i] <= '0;
			end
		end else if (run && tap_weight_commit_in) begin
			live_reg <= load_reg;
		end
	end

	// ---------------------------------------------------------------
	// readiness: load, run, settle after ratio change
	// ---------------------------------------------------------------
	// wait for commit
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg  <= FFP_ST_LOAD;
			settle_reg <= '0;
		end else if (run && sync_clear_in) begin
			state_reg  <= FFP_ST_LOAD;
			settle_reg <= '0;
		end else if (run) begin
			unique case (state_reg)
				FFP_ST_LOAD: begin
					if (tap_weight_commit_in) begin
						state_reg <= FFP_ST_RUN;
					end
				end
				FFP_ST_RUN: begin
					if (ratio_latch_in && upsample_ratio_in != ratio_reg) begin
						state_reg  <= FFP_ST_SETTLE;
						settle_reg <= SETTLE_W'(SETTLE_CYC - 1);
					end
				end
				FFP_ST_SETTLE: begin
					if (settle_reg == '0) begin
						state_reg <= FFP_ST_RUN;
					end else begin
						settle_reg <= settle_reg - 1'b1;
					end
				end
				default: state_reg <= FFP_ST_LOAD;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			accept_ready_out <= 1'b0;
		end else if (run && sync_clear_in) begin
			accept_ready_out <= 1'b0;
		end else if (run) begin
			accept_ready_out <= (state_reg == FFP_ST_RUN) && !ratio_latch_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ratio_reg <= FACTOR_RST;
		end else if (run && sync_clear_in) begin
			ratio_reg <= FACTOR_RST;
		end else if (run && ratio_latch_in) begin
			ratio_reg <= upsample_ratio_in;
		end
	end

	// ---------------------------------------------------------------
	// tap lines
	// ---------------------------------------------------------------
	// even/odd split
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < TAPS; i++) begin
				tap_a_reg[i] <= '0;
				tap_b_reg[i] <= '0;
			end
		end else if (run && sync_clear_in) begin
			for (int i = 0; i < TAPS; i++) begin
				tap_a_reg[i] <= '0;
				tap_b_reg[i] <= '0;
			end
		end else if (take) begin
			unique case (mode_in)
				FFP_HS_SINGLE, FFP_HS_MULTI: begin
					// line a takes the even phase or first channel, line b the other
					tap_a_reg[0] <= pair_in.inphase;
					tap_b_reg[0] <= pair_in.quadrature;
					for (int i = 1; i < TAPS; i++) begin
						tap_a_reg[i] <= tap_a_reg[i-1];
						tap_b_reg[i] <= tap_b_reg[i-1];
					end
				end
				default: begin
					tap_a_reg[0] <= sample_in;
					for (int i = 1; i < TAPS; i++) begin
						tap_a_reg[i] <= tap_a_reg[i-1];
					end
				end
			endcase
		end
	end

	// the mark rides with its captured sample towards the output
	// input mark
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mark_d_reg <= 1'b0;
		end else if (run && sync_clear_in) begin
			mark_d_reg <= 1'b0;
		end else if (take) begin
			mark_d_reg <= first_channel_in_mark_in;
		end
	end

	// ---------------------------------------------------------------
	// result registers
	// ---------------------------------------------------------------
	// results land a cycle after the history moves: plain direct form, fixed latency
	logic take_d_reg;
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			take_d_reg <= 1'b0;
		end else if (run && sync_clear_in) begin
			take_d_reg <= 1'b0;
		end else if (run) begin
			take_d_reg <= take;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sample_out <= '0;
			pair_out   <= '0;
		end else if (run && sync_clear_in) begin
			sample_out <= '0;
			pair_out   <= '0;
		end else if (run && take_d_reg) begin
			sample_out          <= trim(dot(tap_a_reg, live_reg));
			pair_out.inphase    <= trim(dot(tap_a_reg, live_reg));
			pair_out.quadrature <= trim(dot(tap_b_reg, live_reg));
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			result_qualifier_out       <= 1'b0;
			first_channel_out_mark_out <= 1'b0;
		end else if (run && sync_clear_in) begin
			result_qualifier_out       <= 1'b0;
			first_channel_out_mark_out <= 1'b0;
		end else if (run) begin
			result_qualifier_out       <= take_d_reg;
			first_channel_out_mark_out <= take_d_reg && mark_d_reg;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			active_ratio_out <= FACTOR_RST;
		end else if (run && sync_clear_in) begin
			active_ratio_out <= FACTOR_RST;
		end else if (run) begin
			active_ratio_out <= ratio_reg;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	AST_READY_NEEDS_COMMIT: assert property (
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(state_reg == FFP_ST_LOAD) |=> !accept_ready_out)
		else $error("ready high before coefficients committed");

	AST_QUAL_TWO_AFTER_TAKE: assert property (
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(take && clock_gate_enable_in && !sync_clear_in) ##1
		(clock_gate_enable_in && !sync_clear_in)[*2] |-> result_qualifier_out)
		else $error("qualifier missing two cycles after capture");

	AST_NO_QUAL_WITHOUT_TAKE: assert property (
		@(posedge sys_clk_in) disable iff (!resetn_in)
		($rose(result_qualifier_out) && $past(clock_gate_enable_in)
			&& $past(clock_gate_enable_in, 2)) |-> $past(take, 2))
		else $error("qualifier without a captured sample");

	AST_COMMIT_SWAPS: assert property (
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(tap_weight_commit_in && clock_gate_enable_in && !sync_clear_in)
		|=> live_reg[0] == $past(load_reg[0]))
		else $error("commit did not switch weights");

	AST_GATE_FREEZES: assert property (
		@(posedge sys_clk_in) disable iff (!resetn_in)
		!clock_gate_enable_in |=> $stable(accept_ready_out) && $stable(sample_out)
			&& $stable(result_qualifier_out) && $stable(ratio_reg))
		else $error("state moved while gate low");

	AST_CLEAR_RESETS: assert property (
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(sync_clear_in && clock_gate_enable_in) |=> !accept_ready_out
			&& !result_qualifier_out && state_reg == FFP_ST_LOAD)
		else $error("sync clear left state set");

	AST_RATIO_SETTLE: assert property (
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(state_reg == FFP_ST_RUN && ratio_latch_in && clock_gate_enable_in
			&& !sync_clear_in && upsample_ratio_in != ratio_reg)
		|=> !accept_ready_out ##1 !accept_ready_out)
		else $error("ready stayed high across ratio change");

	AST_RATIO_LATCH: assert property (
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(ratio_latch_in && clock_gate_enable_in && !sync_clear_in)
		##1 (clock_gate_enable_in && !sync_clear_in)
		|=> active_ratio_out == $past(upsample_ratio_in, 2))
		else $error("ratio not latched");

	AST_MARK_WITH_QUAL: assert property (
		@(posedge sys_clk_in) disable iff (!resetn_in)
		first_channel_out_mark_out |-> result_qualifier_out)
		else $error("output mark without valid result");

endmodule // ffp_filter_port

`default_nettype wire

// ===== ffp_filter_port_test.sv
// self-checking bench for the filter port block
`timescale 1ns/1ps
`default_nettype none

module ffp_filter_port_test;
	import ffp_pkg::*;

	logic                  sys_clk_in = 1'b0;
	logic                  resetn_in = 1'b0;
	logic                  clear = 1'b0;
	logic                  gate = 1'b1;
	ffp_mode_t             mode = FFP_LOW_SPEED;
	logic [DATA_W-1:0]     smp;
	ffp_pair_in_t          pin;
	logic                  valid, mark_in, ready, qual, mark_out;
	logic [OUT_W-1:0]      sout;
	ffp_pair_out_t         pout;
	logic [COEF_IN_W-1:0]  weight;
	logic                  wr, commit, latch;
	logic [FACTOR_W-1:0]   ratio, act_ratio;
	int                    results;
	int                    err_count = 0;
	int                    checks = 0;

	always #4 sys_clk_in = ~sys_clk_in;

	ffp_filter_port u_ffp_filter_port (
		.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .sync_clear_in(clear),
		.clock_gate_enable_in(gate), .mode_in(mode), .sample_in(smp), .pair_in(pin),
		.sample_in_valid_in(valid), .first_channel_in_mark_in(mark_in),
		.accept_ready_out(ready), .sample_out(sout), .pair_out(pout),
		.result_qualifier_out(qual), .first_channel_out_mark_out(mark_out),
		.tap_weight_in(weight), .tap_weight_write_in(wr), .tap_weight_commit_in(commit),
		.upsample_ratio_in(ratio), .ratio_latch_in(latch), .active_ratio_out(act_ratio));

	ffp_stream_partner u_ffp_stream_partner (
		.clk_in(sys_clk_in), .ready_in(ready), .qual_in(qual), .sample_out(smp),
		.pair_out(pin), .valid_out(valid), .mark_out(mark_in), .weight_out(weight),
		.write_out(wr), .commit_out(commit), .ratio_out(ratio), .latch_out(latch),
		.result_count_out(results));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// n edges, then let their updates land
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask

	task automatic report_and_stop();
		if (err_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// no input accepted before weights are committed
	task automatic t_reset();
		int rw;
		int ww;
		rw = $bits(u_ffp_filter_port.upsample_ratio_in);
		ww = $bits(u_ffp_filter_port.tap_weight_in);
		check("ratio_rst", act_ratio, FACTOR_RST);
		step(5);
		check("ready_preload", ready, 0);
		check("ratio_w", rw, $clog2(MAX_FACTOR + 1));
		check("weight_w", ww, COEF_W + (SYM_INTERP ? (COEF_SIGNED ? 1 : 2) : 0));
	endtask

	task automatic t_load();
		u_ffp_stream_partner.load(16'h4000);
		#1;
		check("ready_commit_edge", ready, 0);
		step(1);
		check("ready_after_commit", ready, 1);
	endtask

	// impulse into zero history: 8 * 0x4000 trims to 2
	task automatic t_stream();
		u_ffp_stream_partner.send(16'h0008, '0, 1'b0);
		#1;
		check("qual_early", qual, 0);
		step(1);
		check("qual_due", qual, 1);
		check("sample_out", sout, 16'h0002);
		step(1);
		check("qual_one_cycle", qual, 0);
		step(4);
		check("ignored_data", results, 1);
	endtask

	task automatic t_ratio();
		int n;
		u_ffp_stream_partner.set_ratio(3'h3);
		#1;
		check("ready_after_latch", ready, 0);
		step(1);
		check("active_ratio", act_ratio, 3'h3);
		n = 1;
		while (ready !== 1'b1 && n < 30) begin
			step(1);
			n++;
		end
		check("settle_len", n, SETTLE_CYC + 1);
		check("ready_back", ready, 1);
		// same value again: only the strobe cycle loses ready
		u_ffp_stream_partner.set_ratio(3'h3);
		#1;
		check("same_ratio_drop", ready, 0);
		step(1);
		check("same_ratio_back", ready, 1);
	endtask

	// a sample presented while frozen must never be taken
	task automatic t_gate();
		gate <= 1'b0;
		u_ffp_stream_partner.send(16'h0008, '0, 1'b0);
		step(4);
		check("frozen_results", results, 1);
		check("frozen_ratio", act_ratio, 3'h3);
		gate <= 1'b1;
		step(4);
		check("gate_no_take", results, 1);
	endtask

	task automatic t_fast();
		mode <= FFP_HS_MULTI;
		u_ffp_stream_partner.send('0, 32'h0010_0020, 1'b1);
		step(1);
		check("multi_qual_mark", {qual, mark_out}, 2'b11);
		// all weights 0x4000: each port shows its own line's sum over four
		check("multi_pair", pout, 32'h0006_0008);
		mode <= FFP_HS_SINGLE;
		u_ffp_stream_partner.send('0, 32'h0003_0004, 1'b0);
		step(1);
		check("single_qual_mark", {qual, mark_out}, 2'b10);
	endtask

	task automatic t_clear();
		clear <= 1'b1;
		step(1);
		clear <= 1'b0;
		check("clear_state", {ready, qual, act_ratio}, {2'b00, FACTOR_RST});
	endtask

	// reset must act between edges
	task automatic t_async();
		u_ffp_stream_partner.load(16'h4000);
		step(3);
		check("ready_before_reset", ready, 1);
		#2;
		resetn_in = 1'b0;
		#1;
		check("async_reset", {ready, act_ratio}, {1'b0, FACTOR_RST});
		// release again mid-run: weights are gone, so no readiness
		@(posedge sys_clk_in);
		resetn_in <= 1'b1;
		step(2);
		check("ready_after_reset", ready, 0);
	endtask

	initial begin
		repeat (4) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		step(1);
		t_reset();
		t_load();
		t_stream();
		t_ratio();
		t_gate();
		t_fast();
		t_clear();
		t_async();
		report_and_stop();
	end

	// watchdog well past the expected run of under a hundred cycles
	initial begin
		#100000;
		err_count++;
		report_and_stop();
	end
endmodule // ffp_filter_port_test

`default_nettype wire

// ===== ffp_pkg.sv
// package of types and constants for the filter port block
package ffp_pkg;
	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int DATA_W       = 16;
	localparam int OUT_W        = 16;
	localparam int COEF_W       = 16;
	localparam int TAPS         = 8;
	localparam int MAX_FACTOR   = 4;
	localparam int FACTOR_W     = $clog2(MAX_FACTOR + 1);
	localparam int TAP_IDX_W    = $clog2(TAPS);
	// coefficient port widening for symmetric interpolation
	localparam bit COEF_SIGNED  = 1'b1;
	localparam bit SYM_INTERP   = 1'b0;
	localparam int COEF_IN_W    = SYM_INTERP ? (COEF_SIGNED ? COEF_W + 1 : COEF_W + 2) : COEF_W;
	localparam int CHANNELS     = 2;
	localparam int CH_W         = 1;
	localparam int ACC_W        = DATA_W + COEF_W + TAP_IDX_W + 1;
	// ---------------------------------------------------------------
	// reset values and timing counts
	// ---------------------------------------------------------------
	localparam logic [FACTOR_W-1:0] FACTOR_RST = 3'h2;
	localparam int  SETTLE_NS      = 48;
	localparam int  CLK_PERIOD_NS  = 8;
	localparam int  SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int  SETTLE_W       = 4;
	// ---------------------------------------------------------------
	// port carriers
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		FFP_LOW_SPEED = 2'h0,
		FFP_HS_SINGLE = 2'h1,
		FFP_HS_MULTI  = 2'h2
	} ffp_mode_t;

	typedef struct packed {
		logic [DATA_W-1:0] inphase;
		logic [DATA_W-1:0] quadrature;
	} ffp_pair_in_t;

	typedef struct packed {
		logic [OUT_W-1:0] inphase;
		logic [OUT_W-1:0] quadrature;
	} ffp_pair_out_t;

	typedef enum logic [1:0] {
		FFP_ST_LOAD   = 2'b00,
		FFP_ST_RUN    = 2'b01,
		FFP_ST_SETTLE = 2'b11
	} ffp_state_t;
endpackage

// ===== ffp_stream_partner.sv
// upstream sample source, coefficient loader and result consumer model
`timescale 1ns/1ps
`default_nettype none

module ffp_stream_partner
	import ffp_pkg::*;
(
	// clock and handshake from the block
	input  wire logic                  clk_in,
	input  wire logic                  ready_in,
	input  wire logic                  qual_in,
	// sample source
	output logic [DATA_W-1:0]          sample_out,
	output ffp_pair_in_t               pair_out,
	output logic                       valid_out,
	output logic                       mark_out,
	// coefficient loader and ratio
	output logic [COEF_IN_W-1:0]       weight_out,
	output logic                       write_out,
	output logic                       commit_out,
	output logic [FACTOR_W-1:0]        ratio_out,
	output logic                       latch_out,
	// consumer tally
	output int                         result_count_out
);
	initial begin
		{sample_out, pair_out, valid_out, mark_out} = '0;
		{weight_out, write_out, commit_out, ratio_out, latch_out} = '0;
	end

	// consumer counts each qualified result
	always @(posedge clk_in) begin
		if (qual_in === 1'b1) result_count_out <= result_count_out + 1;
	end

	// pair carries even/odd or two channels
	task automatic send(input logic [DATA_W-1:0] s, input ffp_pair_in_t p, input logic m);
		int n;
		n = 0;
		while (ready_in !== 1'b1 && n < 50) begin
			@(posedge clk_in);
			n++;
		end
		valid_out <= 1'b1;
		sample_out <= s;
		pair_out <= p;
		mark_out <= m;
		do begin
			@(posedge clk_in);
			n++;
		end while (ready_in !== 1'b1 && n < 50);
		// released sample and pair lines show the inverse, never the last value
		valid_out <= 1'b0;
		sample_out <= ~s;
		pair_out <= ~p;
		mark_out <= 1'b0;
	endtask

	// one unbroken batch in tap order
	task automatic load(input logic [COEF_IN_W-1:0] w);
		for (int k = 0; k < TAPS; k++) begin
			write_out <= 1'b1;
			weight_out <= w;
			@(posedge clk_in);
		end
		write_out <= 1'b0;
		weight_out <= ~w;
		commit_out <= 1'b1;
		@(posedge clk_in);
		commit_out <= 1'b0;
	endtask

	task automatic set_ratio(input logic [FACTOR_W-1:0] r);
		latch_out <= 1'b1;
		ratio_out <= r;
		@(posedge clk_in);
		latch_out <= 1'b0;
	endtask
endmodule // ffp_stream_partner

`default_nettype wire
